// file: inc/vss_pkg.sv
// constants and types for segment sync, polarity, timing and field sync
// assumes one symbol clock drives every register of the block
package vss_pkg;
	localparam int unsigned DATA_W      = 10;
	localparam int unsigned ACC_W       = 16;
	localparam int unsigned SYNC_LEN    = 4;
	localparam int unsigned PN511_LEN   = 511;
	localparam int unsigned PN63_LEN    = 63;
	localparam int unsigned MODE_LEN    = 24;
	localparam int unsigned RSVD_LEN    = 92;
	localparam int unsigned TAIL_LEN    = 12;
	localparam int unsigned SEG_LEN     = SYNC_LEN + PN511_LEN + 3 * PN63_LEN + MODE_LEN
		+ RSVD_LEN + TAIL_LEN;
	localparam int unsigned POS_W       = 10;
	localparam int unsigned FIELD_SEGS  = 313;
	localparam int unsigned FSEG_W      = 9;
	localparam int unsigned PN_END      = SYNC_LEN + PN511_LEN;
	localparam int unsigned PN63A_END   = PN_END + PN63_LEN;
	localparam int unsigned PN63B_END   = PN63A_END + PN63_LEN;
	localparam int unsigned PN63C_END   = PN63B_END + PN63_LEN;
	localparam int unsigned MODE_END    = PN63C_END + MODE_LEN;
	localparam int unsigned RSVD_END    = MODE_END + RSVD_LEN;
	localparam int unsigned LEAK_SHIFT  = 3;
	localparam int unsigned CONF_LOCK   = 4;
	localparam int unsigned CONF_MAX    = 7;
	localparam int unsigned PWM_SHIFT   = 2;
	localparam int unsigned PWM_MAX     = 200;
	localparam int unsigned FCONF_LOCK  = 2;
	localparam int unsigned FCONF_MAX   = 3;
	localparam int unsigned FS_MIN_HITS = 400;
	localparam logic [8:0]  PN_SEED     = 9'h1FF;
	localparam logic [8:0]  PN_TAPS     = 9'h110;

	typedef enum logic [3:0] {
		FP_NONE  = 4'h0,
		FP_SYNC  = 4'h1,
		FP_PN511 = 4'h2,
		FP_PN63A = 4'h3,
		FP_PN63B = 4'h4,
		FP_PN63C = 4'h5,
		FP_MODE  = 4'h6,
		FP_RSVD  = 4'h7,
		FP_TAIL  = 4'h8
	} vss_part_type;
endpackage : vss_pkg

// file: logic/vss_acc_mem.sv
// one-port-read, one-port-write store for per-position sync integrals
// assumes read and write addresses differ in any one cycle
`timescale 1ns/10ps
module vss_acc_mem #(
	parameter int unsigned DEPTH = 832,
	parameter int unsigned WIDTH = 16,
	parameter int unsigned AW    = 10
) (
	input  wire logic             clk_in,
	input  wire logic             wr_en_in,
	input  wire logic [AW-1:0]    wr_addr_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic [AW-1:0]    rd_addr_in,
	output logic      [WIDTH-1:0] rd_data_out
);
	logic [WIDTH-1:0] mem_reg [DEPTH];

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem_reg[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		rd_data_out <= mem_reg[rd_addr_in];
	end
endmodule : vss_acc_mem

// file: logic/vss_seg_sync.sv
// segment sync search, polarity decision, timing phase detector, field sync search
// assumes symbols arrive one per clk_in from logic on the same clock
`timescale 1ns/10ps
module vss_seg_sync (
	input  wire logic                       clk_in,
	input  wire logic                       srst_in,
	input  wire logic signed [vss_pkg::DATA_W-1:0] sym_data_in,
	input  wire logic                       polarity_override_enable_in,
	input  wire logic                       sw_polarity_in,
	output logic                            segment_lock_indicator_out,
	output logic                            timing_start_status_out,
	output logic                            positive_polarity_out,
	output logic                            negative_polarity_out,
	output logic signed [vss_pkg::DATA_W-1:0] corrected_data_out,
	output logic                            charge_up_pulse_low_out,
	output logic                            charge_down_pulse_low_out,
	output logic                            seg_sync_pulse_out,
	output logic                            field_sync_pulse_out,
	output logic                            field_lock_out,
	output vss_pkg::vss_part_type           field_part_out
);
	import vss_pkg::*;

	localparam logic [POS_W-1:0]  SEG_LAST   = POS_W'(SEG_LEN - 1);
	localparam logic [FSEG_W-1:0] FSEG_LAST  = FSEG_W'(FIELD_SEGS - 1);
	localparam logic [2:0]        CONF_LK    = 3'(CONF_LOCK);
	localparam logic [2:0]        CONF_TOP   = 3'(CONF_MAX);
	localparam logic [1:0]        FCONF_LK   = 2'(FCONF_LOCK);
	localparam logic [1:0]        FCONF_TOP  = 2'(FCONF_MAX);
	localparam logic [7:0]        PWM_TOP    = 8'(PWM_MAX);
	localparam logic [8:0]        FS_HITS    = 9'(FS_MIN_HITS);

	// ----------------------------------------
	// input window and position counter
	// ----------------------------------------
	logic signed [DATA_W-1:0] win_reg [SYNC_LEN];
	logic [POS_W-1:0]         pos_reg;
	logic                     clr_reg;

	always_ff @(posedge clk_in) begin
		win_reg[SYNC_LEN-1] <= sym_data_in;
	end

	generate
		for (genvar i = 0; i < SYNC_LEN - 1; i++) begin : g_win
			always_ff @(posedge clk_in) begin
				win_reg[i] <= win_reg[i+1];
			end
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pos_reg <= '0;
		end else begin
			pos_reg <= (pos_reg == SEG_LAST) ? '0 : pos_reg + 1'b1;
		end
	end

	// ----------------------------------------
	// segment correlator, leaky integrator and best-position search
	// ----------------------------------------
	logic signed [11:0]      w0, w1, w2, w3;
	logic signed [11:0]      metric;
	logic signed [11:0]      metric_reg;
	logic [POS_W-1:0]        pos_d1_reg;
	logic [ACC_W-1:0]        rd_data;
	logic signed [ACC_W-1:0] acc_old, acc_new;
	logic signed [16:0]      score;
	logic signed [16:0]      best_score_reg;
	logic [POS_W-1:0]        best_pos_reg;
	logic                    best_neg_reg;
	logic                    take;
	logic [POS_W-1:0]        fin_pos;
	logic                    fin_neg;
	logic                    seg_end;
	logic                    lock_reg;
	logic                    pol_neg_reg;

	assign w0 = 12'(win_reg[0]);
	assign w1 = 12'(win_reg[1]);
	assign w2 = 12'(win_reg[2]);
	assign w3 = 12'(win_reg[3]);
	assign metric = w0 - w1 - w2 + w3;

	always_ff @(posedge clk_in) begin
		metric_reg <= metric;
		pos_d1_reg <= pos_reg;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			clr_reg <= 1'b1;
		end else if (pos_d1_reg == SEG_LAST) begin
			clr_reg <= 1'b0;
		end
	end

	always_comb begin
		acc_old = clr_reg ? '0 : $signed(rd_data);
		acc_new = acc_old - (acc_old >>> LEAK_SHIFT) + ACC_W'(metric_reg);
		if (!lock_reg) begin
			score = (acc_new < 0) ? -17'(acc_new) : 17'(acc_new);
		end else begin
			score = pol_neg_reg ? -17'(acc_new) : 17'(acc_new);
		end
		take    = (pos_d1_reg == '0) || (score > best_score_reg);
		fin_pos = take ? pos_d1_reg : best_pos_reg;
		fin_neg = take ? acc_new[ACC_W-1] : best_neg_reg;
		seg_end = (pos_d1_reg == SEG_LAST);
	end

	vss_acc_mem #(
		.DEPTH (SEG_LEN),
		.WIDTH (ACC_W),
		.AW    (POS_W)
	) u_acc_mem (
		.clk_in      (clk_in),
		.wr_en_in    (1'b1),
		.wr_addr_in  (pos_d1_reg),
		.wr_data_in  (acc_new),
		.rd_addr_in  (pos_reg),
		.rd_data_out (rd_data)
	);

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			best_score_reg <= '0;
			best_pos_reg   <= '0;
			best_neg_reg   <= 1'b0;
		end else if (take) begin
			best_score_reg <= score;
			best_pos_reg   <= pos_d1_reg;
			best_neg_reg   <= acc_new[ACC_W-1];
		end
	end

	// ----------------------------------------
	// confidence counter and lock
	// ----------------------------------------
	logic [2:0]       conf_reg;
	logic [POS_W-1:0] sync_pos_reg;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			conf_reg     <= '0;
			sync_pos_reg <= '0;
		end else if (seg_end) begin
			if (fin_pos == sync_pos_reg) begin
				conf_reg <= (conf_reg == CONF_TOP) ? conf_reg : conf_reg + 1'b1;
			end else if (conf_reg == '0) begin
				sync_pos_reg <= fin_pos;
			end else begin
				conf_reg <= conf_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			lock_reg    <= 1'b0;
			pol_neg_reg <= 1'b0;
		end else if (!lock_reg && conf_reg >= CONF_LK) begin
			lock_reg    <= 1'b1;
			pol_neg_reg <= best_neg_reg;
		end else if (lock_reg && conf_reg == '0) begin
			lock_reg    <= 1'b0;
		end
	end

	// ----------------------------------------
	// polarity outputs and correction
	// ----------------------------------------
	logic pol_sel;
	assign pol_sel = polarity_override_enable_in ? sw_polarity_in : pol_neg_reg;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			positive_polarity_out <= 1'b0;
			negative_polarity_out <= 1'b0;
		end else begin
			positive_polarity_out <= lock_reg && !pol_sel;
			negative_polarity_out <= lock_reg && pol_sel;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			corrected_data_out <= '0;
		end else if (lock_reg && pol_sel) begin
			corrected_data_out <= (sym_data_in == {1'b1, {(DATA_W-1){1'b0}}}) ?
				{1'b0, {(DATA_W-1){1'b1}}} : -sym_data_in;
		end else begin
			corrected_data_out <= sym_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			segment_lock_indicator_out <= 1'b0;
			timing_start_status_out    <= 1'b0;
			seg_sync_pulse_out         <= 1'b0;
		end else begin
			segment_lock_indicator_out <= lock_reg;
			timing_start_status_out    <= lock_reg;
			seg_sync_pulse_out         <= lock_reg && (pos_reg == sync_pos_reg);
		end
	end

	// ----------------------------------------
	// phase detector and charge pulses
	// ----------------------------------------
	logic signed [11:0] pe_raw, pe;
	logic [11:0]        pe_mag;
	logic [7:0]         pwm_width;
	logic [7:0]         pwm_cnt_reg;
	logic               pwm_up_reg;
	logic               pd_fire;

	always_comb begin
		pe_raw    = w2 + w3 - w0 - w1;
		pe        = pol_sel ? -pe_raw : pe_raw;
		pe_mag    = (pe < 0) ? 12'(-pe) : 12'(pe);
		pwm_width = ((pe_mag >> PWM_SHIFT) > 12'(PWM_TOP)) ? PWM_TOP : 8'(pe_mag >> PWM_SHIFT);
		pd_fire   = lock_reg && (pos_reg == sync_pos_reg);
	end

	always_ff @(posedge clk_in) begin
		if (srst_in || !lock_reg) begin
			pwm_cnt_reg <= '0;
			pwm_up_reg  <= 1'b0;
		end else if (pd_fire) begin
			pwm_cnt_reg <= pwm_width;
			pwm_up_reg  <= (pe > 0);
		end else if (pwm_cnt_reg != '0) begin
			pwm_cnt_reg <= pwm_cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in || !lock_reg) begin
			charge_up_pulse_low_out   <= 1'b0;
			charge_down_pulse_low_out <= 1'b0;
		end else begin
			charge_up_pulse_low_out   <= !((pwm_cnt_reg != '0) && pwm_up_reg);
			charge_down_pulse_low_out <= !((pwm_cnt_reg != '0) && !pwm_up_reg);
		end
	end

	// ----------------------------------------
	// field sync search
	// ----------------------------------------
	logic [POS_W-1:0]  sidx_reg;
	logic [8:0]        pn_reg;
	logic [8:0]        hits_reg;
	logic [FSEG_W-1:0] fseg_reg;
	logic [FSEG_W-1:0] fbest_idx_reg;
	logic [8:0]        fbest_hits_reg;
	logic [FSEG_W-1:0] field_idx_reg;
	logic [1:0]        fconf_reg;
	logic              in_pn;
	logic              sym_pos;
	logic              fs_end;
	logic              ftake;
	logic [FSEG_W-1:0] ffin_idx;

	assign in_pn   = (sidx_reg >= POS_W'(SYNC_LEN)) && (sidx_reg < POS_W'(PN_END));
	assign sym_pos = ~(win_reg[SYNC_LEN-1][DATA_W-1] ^ pol_sel);
	assign fs_end  = (sidx_reg == SEG_LAST);
	assign ftake   = (fseg_reg == '0) || (hits_reg > fbest_hits_reg);
	assign ffin_idx = ftake ? fseg_reg : fbest_idx_reg;

	always_ff @(posedge clk_in) begin
		if (srst_in || !lock_reg) begin
			sidx_reg <= '0;
			pn_reg   <= PN_SEED;
			hits_reg <= '0;
		end else if (pos_reg == sync_pos_reg) begin
			sidx_reg <= POS_W'(SYNC_LEN);
			pn_reg   <= PN_SEED;
			hits_reg <= '0;
		end else begin
			sidx_reg <= fs_end ? '0 : sidx_reg + 1'b1;
			if (in_pn) begin
				pn_reg   <= {pn_reg[7:0], ^(pn_reg & PN_TAPS)};
				hits_reg <= hits_reg + 9'(sym_pos == pn_reg[8]);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in || !lock_reg) begin
			fseg_reg       <= '0;
			fbest_idx_reg  <= '0;
			fbest_hits_reg <= '0;
			field_idx_reg  <= '0;
			fconf_reg      <= '0;
		end else if (fs_end) begin
			fseg_reg <= (fseg_reg == FSEG_LAST) ? '0 : fseg_reg + 1'b1;
			if (ftake) begin
				fbest_idx_reg  <= fseg_reg;
				fbest_hits_reg <= hits_reg;
			end
			if (fseg_reg == FSEG_LAST) begin
				if (ffin_idx == field_idx_reg && (ftake ? hits_reg : fbest_hits_reg) >= FS_HITS) begin
					fconf_reg <= (fconf_reg == FCONF_TOP) ? fconf_reg : fconf_reg + 1'b1;
				end else if (fconf_reg == '0) begin
					field_idx_reg <= ffin_idx;
				end else begin
					fconf_reg <= fconf_reg - 1'b1;
				end
			end
		end
	end

	function automatic vss_part_type part_of(input logic [POS_W-1:0] s);
		vss_part_type p;
		p = FP_TAIL;
		if (s < POS_W'(SYNC_LEN)) p = FP_SYNC;
		else if (s < POS_W'(PN_END)) p = FP_PN511;
		else if (s < POS_W'(PN63A_END)) p = FP_PN63A;
		else if (s < POS_W'(PN63B_END)) p = FP_PN63B;
		else if (s < POS_W'(PN63C_END)) p = FP_PN63C;
		else if (s < POS_W'(MODE_END)) p = FP_MODE;
		else if (s < POS_W'(RSVD_END)) p = FP_RSVD;
		return p;
	endfunction : part_of

	logic in_field;
	assign in_field = (fconf_reg >= FCONF_LK) && (fseg_reg == field_idx_reg);

	always_ff @(posedge clk_in) begin
		if (srst_in || !lock_reg) begin
			field_lock_out       <= 1'b0;
			field_sync_pulse_out <= 1'b0;
			field_part_out       <= FP_NONE;
		end else begin
			field_lock_out       <= (fconf_reg >= FCONF_LK);
			field_sync_pulse_out <= in_field && (sidx_reg == '0);
			field_part_out       <= in_field ? part_of(sidx_reg) : FP_NONE;
		end
	end
endmodule : vss_seg_sync

// file: sim/tb_top.sv
// self-checking bench for segment sync, polarity and charge pulses
// assumes the demodulator model and the bound checker compile first
`timescale 1ns/10ps
module tb_top;
	import vss_pkg::*;
	localparam int SEG      = SEG_LEN;
	localparam int SKEWS[4] = '{20, -30, 250, 0};
	logic                     clk_in = 1'b0;
	logic                     srst_in = 1'b1;
	logic                     ovr_en = 1'b0;
	logic                     sw_pol = 1'b0;
	logic                     invert = 1'b0;
	logic                     dtrack = 1'b0;
	logic                     pmon = 1'b0;
	logic                     neg_exp = 1'b0;
	logic signed [DATA_W-1:0] skew = 10'sh000;
	logic [15:0]              rnd = 16'h43BE;
	logic signed [DATA_W-1:0] sym;
	logic signed [DATA_W-1:0] cdata;
	logic                     lock, start, pos, neg, up_low, dn_low, seg_p;
	logic                     flock, fsp;
	vss_part_type             fpart;
	logic signed [DATA_W-1:0] dq[$];
	int                       pq[$];
	int                       miscompares = 0;
	int                       checks = 0;
	int                       cnt = 0;
	int                       dir = 0;
	// ----------------------------------------
	// clock, random source, instances
	// ----------------------------------------
	initial forever #20 clk_in = ~clk_in;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	always @(negedge clk_in) rnd <= lfsr(rnd);
	vss_demod_model i_vss_demod_model (.clk_in(clk_in), .invert_in(invert), .skew_in(skew),
		.rnd_in(rnd), .sym_out(sym));
	vss_seg_sync i_vss_seg_sync (.clk_in(clk_in), .srst_in(srst_in), .sym_data_in(sym),
		.polarity_override_enable_in(ovr_en), .sw_polarity_in(sw_pol),
		.segment_lock_indicator_out(lock), .timing_start_status_out(start),
		.positive_polarity_out(pos), .negative_polarity_out(neg), .corrected_data_out(cdata),
		.charge_up_pulse_low_out(up_low), .charge_down_pulse_low_out(dn_low),
		.seg_sync_pulse_out(seg_p), .field_sync_pulse_out(fsp), .field_lock_out(flock),
		.field_part_out(fpart));
	// ----------------------------------------
	// compare, finish, waits
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %0h, seen %0h", name, exp, got);
		end
	endtask : chk
	task automatic summarize();
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	task automatic wait_lock(input logic val, input int lim);
		for (int i = 0; i < lim && lock !== val; i++) @(negedge clk_in);
		chk("segment_lock_indicator", 32'(val), 32'(lock));
	endtask : wait_lock
	// ----------------------------------------
	// expectation notes and output monitor
	// ----------------------------------------
	always @(posedge clk_in) begin
		if (dtrack) dq.push_back(neg_exp ? ((sym == 10'sh200) ? 10'sh1FF : -sym) : sym);
	end
	always @(posedge clk_in) begin
		#1;
		if (dq.size() > 0) chk("corrected_data", dq.pop_front(), cdata);
		if (pmon && (!up_low || !dn_low)) begin
			cnt++;
			dir = up_low ? -1 : 1;
		end else if (pmon && cnt > 0) begin
			chk("pulse_width", (pq.size() > 0) ? pq.pop_front() : 0, cnt * dir);
			cnt = 0;
		end
	end
	initial begin
		repeat (72 * SEG) @(posedge clk_in);
		miscompares++;
		summarize();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		int w;
		repeat (2) @(negedge clk_in);
		srst_in = 1'b0;
		chk("outputs_after_reset", 0, {lock, start, pos, neg, up_low, dn_low});
		dtrack = 1'b1;
		wait_lock(1'b1, 12 * SEG);
		repeat (3) @(negedge clk_in);
		chk("timing_start", 1, start);
		chk("polarity_pair", 2'b10, {pos, neg});
		chk("charge_rest", 2'b11, {up_low, dn_low});
		foreach (SKEWS[k]) begin
			skew = 10'(SKEWS[k]);
			w = (SKEWS[k] < 0) ? -SKEWS[k] : SKEWS[k];
			w = (w > PWM_MAX) ? PWM_MAX : w;
			w = (SKEWS[k] < 0) ? -w : w;
			repeat (2 * SEG) @(negedge clk_in);
			for (int j = 0; j < SEG && !seg_p; j++) @(negedge clk_in);
			repeat (SEG / 2) @(negedge clk_in);
			cnt = 0;
			pmon = 1'b1;
			if (w != 0) pq = '{w, w};
			repeat (2 * SEG) @(negedge clk_in);
			pmon = 1'b0;
			chk("pulses_missing", 0, pq.size());
		end
		dtrack = 1'b0;
		repeat (2) @(negedge clk_in);
		{ovr_en, sw_pol} = 2'b11;
		repeat (2) @(negedge clk_in);
		chk("override_negative", 2'b01, {pos, neg});
		sw_pol = 1'b0;
		repeat (2) @(negedge clk_in);
		chk("override_positive", 2'b10, {pos, neg});
		{ovr_en, sw_pol} = 2'b01;
		repeat (2) @(negedge clk_in);
		chk("override_off", 2'b10, {pos, neg});
		invert = 1'b1;
		wait_lock(1'b0, 20 * SEG);
		srst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		srst_in = 1'b0;
		wait_lock(1'b1, 12 * SEG);
		repeat (3) @(negedge clk_in);
		chk("negative_pair", 2'b01, {pos, neg});
		neg_exp = 1'b1;
		dtrack = 1'b1;
		repeat (SEG) @(negedge clk_in);
		dtrack = 1'b0;
		repeat (2) @(negedge clk_in);
		chk("field_outputs", {2'b00, FP_NONE}, {flock, fsp, fpart});
		summarize();
	end
endmodule : tb_top

// file: sim/vss_demod_model.sv
// symbol source standing in for the off-chip demodulator
// assumes the bench hands it a fresh random word every clock
`timescale 1ns/10ps
module vss_demod_model (
	input  wire logic                                 clk_in,
	input  wire logic                                 invert_in,
	input  wire logic signed [vss_pkg::DATA_W-1:0]    skew_in,
	input  wire logic [15:0]                          rnd_in,
	output logic signed [vss_pkg::DATA_W-1:0]         sym_out
);
	import vss_pkg::*;
	localparam logic signed [DATA_W-1:0] AMP = 10'sh0A0;
	logic [POS_W-1:0]         pos_reg = 10'h000;
	logic signed [DATA_W-1:0] val;
	initial sym_out = 10'sh000;
	// skew shifts the sync symbols off centre, giving phase error 4*skew
	always_comb begin
		case (pos_reg)
			10'h000: val = AMP - skew_in;
			10'h001: val = -AMP - skew_in;
			10'h002: val = -AMP + skew_in;
			10'h003: val = AMP + skew_in;
			default: val = {{4{rnd_in[5]}}, rnd_in[5:0]};
		endcase
	end
	// no field sync segment is sent, so the 313-segment spacing never occurs
	// carrier locked out of phase inverts every symbol
	always @(negedge clk_in) begin
		pos_reg <= (pos_reg == POS_W'(SEG_LEN - 1)) ? 10'h000 : pos_reg + 10'h001;
		sym_out <= invert_in ? -val : val;
	end
endmodule : vss_demod_model

// file: sim/vss_seg_sync_sva.sv
// checker for lock, polarity, charge pulses and data correction
// assumes it is bound to vss_seg_sync and sees only its ports
`timescale 1ns/10ps
module vss_seg_sync_sva (
	input wire logic                              clk_in,
	input wire logic                              srst_in,
	input wire logic signed [vss_pkg::DATA_W-1:0] sym_data_in,
	input wire logic                              polarity_override_enable_in,
	input wire logic                              sw_polarity_in,
	input wire logic                              segment_lock_indicator_out,
	input wire logic                              timing_start_status_out,
	input wire logic                              positive_polarity_out,
	input wire logic                              negative_polarity_out,
	input wire logic signed [vss_pkg::DATA_W-1:0] corrected_data_out,
	input wire logic                              charge_up_pulse_low_out,
	input wire logic                              charge_down_pulse_low_out,
	input wire logic                              seg_sync_pulse_out
);
	import vss_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	int unsigned low_cnt_reg;
	wire logic   lock = segment_lock_indicator_out;
	wire logic   rest = charge_up_pulse_low_out && charge_down_pulse_low_out;
	// length of the current charge pulse
	always_ff @(posedge clk_in) begin
		if (srst_in || rest || !timing_start_status_out) begin
			low_cnt_reg <= 0;
		end else begin
			low_cnt_reg <= low_cnt_reg + 1;
		end
	end
	AST_START_FOLLOWS_LOCK: assert property (timing_start_status_out == lock)
		else $error("timing start differs from lock");
	AST_POL_CLEAR: assert property (!lock |->
		!positive_polarity_out && !negative_polarity_out)
		else $error("polarity output set before lock");
	AST_POL_ONE_HOT: assert property (lock |->
		positive_polarity_out != negative_polarity_out)
		else $error("polarity outputs not one hot");
	AST_POL_OVERRIDE: assert property (lock && $past(polarity_override_enable_in) |->
		negative_polarity_out == $past(sw_polarity_in) &&
		positive_polarity_out == !$past(sw_polarity_in))
		else $error("override polarity not followed");
	AST_POL_HELD: assert property (lock && $past(lock) && !$past(polarity_override_enable_in)
		&& !$past(polarity_override_enable_in, 2) |-> $stable(negative_polarity_out))
		else $error("polarity changed while locked");
	AST_CHG_IDLE: assert property (!timing_start_status_out |->
		!charge_up_pulse_low_out && !charge_down_pulse_low_out)
		else $error("charge output high before timing start");
	AST_CHG_NOT_BOTH: assert property (timing_start_status_out
		&& $past(timing_start_status_out) |-> charge_up_pulse_low_out || charge_down_pulse_low_out)
		else $error("both charge outputs low while locked");
	AST_PULSE_CAP: assert property (low_cnt_reg <= PWM_MAX)
		else $error("charge pulse too long");
	AST_DATA_PASS: assert property (!$past(srst_in) && !$past(lock) && !lock
		|-> corrected_data_out == $past(sym_data_in))
		else $error("unlocked data not passed through");
	AST_SYNC_PULSE: assert property (lock && seg_sync_pulse_out |=> !seg_sync_pulse_out [*8])
		else $error("sync pulse repeats too soon");
	cover property ($rose(lock));
	cover property ($fell(charge_up_pulse_low_out));
	cover property ($fell(charge_down_pulse_low_out));
	cover property (lock && negative_polarity_out);
endmodule : vss_seg_sync_sva
bind vss_seg_sync vss_seg_sync_sva i_vss_seg_sync_sva (.clk_in(clk_in), .srst_in(srst_in),
	.sym_data_in(sym_data_in), .polarity_override_enable_in(polarity_override_enable_in),
	.sw_polarity_in(sw_polarity_in), .segment_lock_indicator_out(segment_lock_indicator_out),
	.timing_start_status_out(timing_start_status_out), .positive_polarity_out(positive_polarity_out),
	.negative_polarity_out(negative_polarity_out), .corrected_data_out(corrected_data_out),
	.charge_up_pulse_low_out(charge_up_pulse_low_out), .seg_sync_pulse_out(seg_sync_pulse_out),
	.charge_down_pulse_low_out(charge_down_pulse_low_out));
